// ### inc/dbgp_cfg.svh
// Constants of the two-wire debug port physical layer: field sizes, run lengths and timing.
`ifndef DBGP_CFG_SVH
`define DBGP_CFG_SVH

`define DBGP_DATA_BITS 8
`define DBGP_STOP_BITS 2
`define DBGP_CHAR_RUN 12
`define DBGP_ACT_HIGH_CYCLES 16
`define DBGP_GUARD_MIN 2
`define DBGP_GUARD_DEFAULT 128
`define DBGP_MCLK_PERIOD_NS 8
`define DBGP_START_WINDOW_US 100
`define DBGP_IDLE_FREQ_KHZ 10
`define DBGP_RST_PULSE_NS 1000

// Longest times round down, least times round up.
`define DBGP_START_WINDOW_CYC ((`DBGP_START_WINDOW_US * 1000) / `DBGP_MCLK_PERIOD_NS)
`define DBGP_IDLE_CYC ((1000000 / `DBGP_IDLE_FREQ_KHZ) / `DBGP_MCLK_PERIOD_NS)
`define DBGP_RST_PULSE_CYC ((`DBGP_RST_PULSE_NS + `DBGP_MCLK_PERIOD_NS - 1) / `DBGP_MCLK_PERIOD_NS)

`endif

// ### inc/dbgp_pkg.sv
// Types shared by the two-wire debug port physical layer.
`include "dbgp_cfg.svh"
package dbgp_pkg;

	typedef enum logic [2:0] {
		dbgp_rx_wait,
		dbgp_rx_frame,
		dbgp_rx_hold_high,
		dbgp_tx_guard,
		dbgp_tx_fill,
		dbgp_tx_frame,
		dbgp_tx_coll
	} dbgp_link_st_t;

	typedef enum logic [1:0] {
		dbgp_off,
		dbgp_hold,
		dbgp_armed,
		dbgp_on
	} dbgp_act_st_t;

	typedef struct packed {
		logic [`DBGP_DATA_BITS-1:0] data;
		logic byte_ok;
		logic par_err;
		logic frm_err;
		logic brk;
		logic coll;
	} dbgp_evt_t;

endpackage : dbgp_pkg

// ### core/dbgp_sync.sv
// Three-stage synchroniser; a bit changes once its second and third stages agree.
module dbgp_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	if (W < 1) begin : g_bad_width
		$error("dbgp_sync needs at least one bit");
	end

	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] q_reg;
	logic [W-1:0] q_next;

	always_comb begin
		q_next = q_reg;
		for (int i = 0; i < W; i++) begin
			if (s2_reg[i] == s3_reg[i]) begin
				q_next[i] = s2_reg[i];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			q_reg <= '0;
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			q_reg <= q_next;
		end
	end

	assign q = q_reg;
endmodule : dbgp_sync

// ### core/dbgp_act.sv
// Port activation, start window, inactivity shutdown and reset-pin function control.
`include "dbgp_cfg.svh"
module dbgp_act #(
	parameter int START_CYC = `DBGP_START_WINDOW_CYC,
	parameter int IDLE_CYC = `DBGP_IDLE_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic data_hi,
	input wire logic clk_line,
	input wire logic beat,
	input wire logic act_done,
	input wire logic fuse_keep_rst_dis,
	output logic link_run,
	output logic port_on,
	output logic rst_fn_en,
	output logic core_rst_hold
);
	localparam int PULSE_CYC = `DBGP_RST_PULSE_CYC;
	localparam int MAX_A = (START_CYC > IDLE_CYC) ? START_CYC : IDLE_CYC;
	localparam int MAX_C = (MAX_A > PULSE_CYC) ? MAX_A : PULSE_CYC;
	localparam int CW = $clog2(MAX_C + 1);

	if (START_CYC < 1 || IDLE_CYC < 1) begin : g_bad_counts
		$error("dbgp_act counts must be at least one cycle");
	end

	dbgp_pkg::dbgp_act_st_t st_reg;
	dbgp_pkg::dbgp_act_st_t st_next;
	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;
	logic seen_reg;
	logic seen_next;
	logic hold_reg;
	logic hold_next;

	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg + 1'b1;
		seen_next = seen_reg;
		hold_next = hold_reg;
		unique case (st_reg)
			dbgp_pkg::dbgp_off: begin
				seen_next = 1'b0;
				cnt_next = '0;
				if (data_hi) begin
					st_next = dbgp_pkg::dbgp_hold;
				end
			end
			dbgp_pkg::dbgp_hold: begin
				if (!data_hi) begin
					st_next = dbgp_pkg::dbgp_off;
				end else if (cnt_reg == CW'(PULSE_CYC)) begin
					st_next = dbgp_pkg::dbgp_armed;
					cnt_next = '0;
				end
			end
			dbgp_pkg::dbgp_armed: begin
				if (beat) begin
					seen_next = 1'b1;
					cnt_next = '0;
				end
				if (!seen_reg && !beat && cnt_reg == CW'(START_CYC - 1)) begin
					st_next = dbgp_pkg::dbgp_off;
				end else if (seen_reg && !beat && cnt_reg == CW'(IDLE_CYC - 1)) begin
					st_next = dbgp_pkg::dbgp_off;
				end else if (act_done) begin
					st_next = dbgp_pkg::dbgp_on;
					hold_next = !clk_line;
					cnt_next = '0;
				end
			end
			dbgp_pkg::dbgp_on: begin
				if (beat) begin
					cnt_next = '0;
				end else if (cnt_reg == CW'(IDLE_CYC - 1)) begin
					st_next = dbgp_pkg::dbgp_off;
					hold_next = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= dbgp_pkg::dbgp_off;
			cnt_reg <= '0;
			seen_reg <= 1'b0;
			hold_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			seen_reg <= seen_next;
			hold_reg <= hold_next;
		end
	end

	assign link_run = (st_reg == dbgp_pkg::dbgp_armed) || (st_reg == dbgp_pkg::dbgp_on);
	assign port_on = (st_reg == dbgp_pkg::dbgp_on);
	// The pin regains its reset role only once the port is off again and no fuse overrides it.
	assign rst_fn_en = !fuse_keep_rst_dis && !link_run;
	assign core_rst_hold = hold_reg;
endmodule : dbgp_act

// ### core/dbgp_phy.sv
// Two-wire debug port physical layer: link framing on the debug clock, hand-off on mclk.
`include "dbgp_cfg.svh"
module dbgp_phy #(
	parameter int START_CYC = `DBGP_START_WINDOW_CYC,
	parameter int IDLE_CYC = `DBGP_IDLE_CYC,
	parameter int GW = 8
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic debug_clock_line,
	input wire logic debug_data_line_i,
	output logic debug_data_line_o,
	output logic debug_data_line_oe_b,
	input wire logic fuse_keep_rst_dis,
	input wire logic [GW-1:0] guard_cfg,
	input wire logic ctl_tx_mode,
	input wire logic tx_valid,
	input wire logic [`DBGP_DATA_BITS-1:0] tx_data,
	output logic tx_ready,
	output logic rx_valid,
	output logic [`DBGP_DATA_BITS-1:0] rx_data,
	output logic rx_parity_err,
	output logic rx_frame_err,
	output logic rx_break,
	output logic rx_collision,
	output logic port_active,
	output logic rst_fn_en,
	output logic core_rst_hold
);
	localparam int DW = `DBGP_DATA_BITS;
	localparam int FW = DW + 1 + `DBGP_STOP_BITS;

	if (GW < 8) begin : g_bad_guard
		$error("dbgp_phy guard counter must hold the default guard time");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Link domain state, on the debug clock.

	dbgp_pkg::dbgp_link_st_t lst_reg;
	dbgp_pkg::dbgp_link_st_t lst_next;
	logic [GW-1:0] lcnt_reg;
	logic [GW-1:0] lcnt_next;
	logic [FW-1:0] lsh_reg;
	logic [FW-1:0] lsh_next;
	logic [3:0] low_run_reg;
	logic [3:0] low_run_next;
	logic [4:0] act_cnt_reg;
	logic [4:0] act_cnt_next;
	logic act_done_reg;
	logic act_done_next;
	logic beat_reg;
	logic beat_next;
	dbgp_pkg::dbgp_evt_t evt_reg;
	dbgp_pkg::dbgp_evt_t evt_next;
	logic evt_tgl_reg;
	logic evt_tgl_next;
	logic ack_tgl_reg;
	logic ack_tgl_next;
	logic bit_reg;
	logic bit_next;
	logic pin_bit_reg;
	logic pin_bit_next;
	logic pin_drv_reg;
	logic pin_drv_next;
	logic pin_tx_reg;
	logic pin_tx_next;

	logic [2:0] lsync_q;
	logic run_s;
	logic req_s;
	logic mode_s;
	logic din;
	logic tx_act;
	logic brk_now;
	logic coll_now;
	logic [GW-1:0] guard_eff;

	// System side registers, declared here because the link reads the held byte.
	logic [DW-1:0] tx_byte_reg;
	logic [DW-1:0] tx_byte_next;
	logic tx_req_reg;
	logic tx_req_next;
	logic link_run;

	function automatic dbgp_pkg::dbgp_evt_t frame_check(input logic [FW-1:0] f);
		dbgp_pkg::dbgp_evt_t e;
		e = '0;
		e.data = f[DW-1:0];
		e.par_err = ^f[DW:0];
		e.frm_err = !(&f[FW-1:DW+1]);
		e.byte_ok = !e.par_err && !e.frm_err;
		return e;
	endfunction : frame_check

	dbgp_sync #(.W(3)) u_link_sync (
		.clk(debug_clock_line),
		.rst_b(rst_b),
		.d({link_run, tx_req_reg, ctl_tx_mode}),
		.q(lsync_q)
	);

	assign run_s = lsync_q[2];
	assign req_s = lsync_q[1];
	assign mode_s = lsync_q[0];
	// The data line is sampled straight on the rising link edge: it is launched on the
	// falling edge of that same clock, so it needs no synchroniser here.
	assign din = debug_data_line_i;
	assign tx_act = (lst_reg == dbgp_pkg::dbgp_tx_guard) || (lst_reg == dbgp_pkg::dbgp_tx_fill)
		|| (lst_reg == dbgp_pkg::dbgp_tx_frame);
	assign brk_now = !din && (low_run_reg == 4'(`DBGP_CHAR_RUN - 1));
	assign coll_now = tx_act && pin_tx_reg && !pin_drv_reg && (din != pin_bit_reg);
	// Guard setting is taken as quasi-static; change it only while the port receives.
	assign guard_eff = (guard_cfg == '0) ? GW'(`DBGP_GUARD_DEFAULT)
		: (guard_cfg < GW'(`DBGP_GUARD_MIN)) ? GW'(`DBGP_GUARD_MIN) : guard_cfg;

	always_comb begin
		lst_next = lst_reg;
		lcnt_next = lcnt_reg;
		lsh_next = lsh_reg;
		low_run_next = din ? 4'h0
			: ((low_run_reg == 4'(`DBGP_CHAR_RUN)) ? low_run_reg : low_run_reg + 4'h1);
		act_cnt_next = act_cnt_reg;
		act_done_next = act_done_reg;
		beat_next = !beat_reg;
		evt_next = evt_reg;
		evt_tgl_next = evt_tgl_reg;
		ack_tgl_next = ack_tgl_reg;
		bit_next = 1'b1;
		if (!run_s) begin
			lst_next = dbgp_pkg::dbgp_rx_wait;
			act_cnt_next = '0;
			act_done_next = 1'b0;
			ack_tgl_next = req_s;
		end else if (!act_done_reg) begin
			act_cnt_next = din ? act_cnt_reg + 5'h01 : 5'h00;
			if (din && act_cnt_reg == 5'(`DBGP_ACT_HIGH_CYCLES - 1)) begin
				act_done_next = 1'b1;
			end
		end else if (coll_now) begin
			evt_next = '0;
			evt_next.coll = 1'b1;
			evt_tgl_next = !evt_tgl_reg;
			lst_next = dbgp_pkg::dbgp_tx_coll;
			lcnt_next = '0;
		end else begin
			unique case (lst_reg)
				dbgp_pkg::dbgp_rx_wait: begin
					if (!din) begin
						lst_next = dbgp_pkg::dbgp_rx_frame;
						lcnt_next = '0;
					end else if (mode_s) begin
						lst_next = dbgp_pkg::dbgp_tx_guard;
						lcnt_next = '0;
					end
				end
				dbgp_pkg::dbgp_rx_frame: begin
					lsh_next = {din, lsh_reg[FW-1:1]};
					lcnt_next = lcnt_reg + 1'b1;
					if (brk_now) begin
						evt_next = '0;
						evt_next.brk = 1'b1;
						evt_tgl_next = !evt_tgl_reg;
						lst_next = dbgp_pkg::dbgp_rx_hold_high;
					end else if (lcnt_reg == GW'(FW - 1)) begin
						evt_next = frame_check({din, lsh_reg[FW-1:1]});
						evt_tgl_next = !evt_tgl_reg;
						lst_next = dbgp_pkg::dbgp_rx_wait;
					end
				end
				dbgp_pkg::dbgp_rx_hold_high: begin
					// A long abort must not be mistaken for a fresh start bit.
					if (din) begin
						lst_next = dbgp_pkg::dbgp_rx_wait;
					end
				end
				dbgp_pkg::dbgp_tx_guard: begin
					lcnt_next = lcnt_reg + 1'b1;
					if (lcnt_reg == guard_eff - GW'(2)) begin
						lst_next = dbgp_pkg::dbgp_tx_fill;
					end
				end
				dbgp_pkg::dbgp_tx_fill: begin
					if (req_s != ack_tgl_reg) begin
						lsh_next = {{`DBGP_STOP_BITS{1'b1}}, ^tx_byte_reg, tx_byte_reg};
						ack_tgl_next = req_s;
						bit_next = 1'b0;
						lst_next = dbgp_pkg::dbgp_tx_frame;
						lcnt_next = '0;
					end else if (!mode_s) begin
						lst_next = dbgp_pkg::dbgp_rx_wait;
					end
				end
				dbgp_pkg::dbgp_tx_frame: begin
					bit_next = lsh_reg[0];
					lsh_next = {1'b1, lsh_reg[FW-1:1]};
					lcnt_next = lcnt_reg + 1'b1;
					if (lcnt_reg == GW'(FW - 1)) begin
						lst_next = dbgp_pkg::dbgp_tx_fill;
					end
				end
				dbgp_pkg::dbgp_tx_coll: begin
					// The low run of the colliding abort is spent here; only an abort that
					// follows a high bit counts.
					if (din) begin
						lcnt_next = GW'(1);
					end
					if (lcnt_reg != '0 && brk_now) begin
						evt_next = '0;
						evt_next.brk = 1'b1;
						evt_tgl_next = !evt_tgl_reg;
						lst_next = dbgp_pkg::dbgp_rx_hold_high;
					end
				end
				default: begin
					lst_next = dbgp_pkg::dbgp_rx_wait;
				end
			endcase
		end
	end

	always_ff @(posedge debug_clock_line or negedge rst_b) begin
		if (!rst_b) begin
			lst_reg <= dbgp_pkg::dbgp_rx_wait;
			lcnt_reg <= '0;
			lsh_reg <= '0;
			low_run_reg <= 4'h0;
			act_cnt_reg <= 5'h00;
			act_done_reg <= 1'b0;
			beat_reg <= 1'b0;
			evt_reg <= '0;
			evt_tgl_reg <= 1'b0;
			ack_tgl_reg <= 1'b0;
			bit_reg <= 1'b1;
		end else begin
			lst_reg <= lst_next;
			lcnt_reg <= lcnt_next;
			lsh_reg <= lsh_next;
			low_run_reg <= low_run_next;
			act_cnt_reg <= act_cnt_next;
			act_done_reg <= act_done_next;
			beat_reg <= beat_next;
			evt_reg <= evt_next;
			evt_tgl_reg <= evt_tgl_next;
			ack_tgl_reg <= ack_tgl_next;
			bit_reg <= bit_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin driver, on the falling link edge.

	always_comb begin
		pin_bit_next = tx_act ? bit_reg : pin_bit_reg;
		pin_drv_next = tx_act && (bit_reg != pin_bit_reg);
		pin_tx_next = tx_act;
	end

	always_ff @(negedge debug_clock_line or negedge rst_b) begin
		if (!rst_b) begin
			pin_bit_reg <= 1'b1;
			pin_drv_reg <= 1'b0;
			pin_tx_reg <= 1'b0;
		end else begin
			pin_bit_reg <= pin_bit_next;
			pin_drv_reg <= pin_drv_next;
			pin_tx_reg <= pin_tx_next;
		end
	end

	assign debug_data_line_o = pin_bit_reg;
	assign debug_data_line_oe_b = !pin_drv_reg;

	////////////////////////////////////////////////////////////////////////////////
	// System side on mclk: activation, received events and the transmit hand-off.

	logic [5:0] msync_q;
	logic data_s;
	logic clkl_s;
	logic beat_s;
	logic done_s;
	logic evt_s;
	logic ack_s;
	logic beat_last_reg;
	logic evt_seen_reg;
	logic evt_seen_next;
	logic new_evt;
	logic [DW-1:0] rx_data_reg;
	logic [DW-1:0] rx_data_next;
	logic [4:0] rx_flag_reg;
	logic [4:0] rx_flag_next;

	dbgp_sync #(.W(6)) u_sys_sync (
		.clk(mclk),
		.rst_b(rst_b),
		.d({debug_data_line_i, debug_clock_line, beat_reg, act_done_reg, evt_tgl_reg,
			ack_tgl_reg}),
		.q(msync_q)
	);

	assign {data_s, clkl_s, beat_s, done_s, evt_s, ack_s} = msync_q;

	dbgp_act #(.START_CYC(START_CYC), .IDLE_CYC(IDLE_CYC)) u_act (
		.clk(mclk),
		.rst_b(rst_b),
		.data_hi(data_s),
		.clk_line(clkl_s),
		.beat(beat_s != beat_last_reg),
		.act_done(done_s),
		.fuse_keep_rst_dis(fuse_keep_rst_dis),
		.link_run(link_run),
		.port_on(port_active),
		.rst_fn_en(rst_fn_en),
		.core_rst_hold(core_rst_hold)
	);

	assign new_evt = (evt_s != evt_seen_reg);
	assign tx_ready = port_active && (tx_req_reg == ack_s);

	always_comb begin
		evt_seen_next = evt_s;
		// The event word was settled on the same link edge as its toggle, several mclk cycles before the toggle got here.
		rx_flag_next = new_evt ? {evt_reg.byte_ok, evt_reg.par_err, evt_reg.frm_err,
			evt_reg.brk, evt_reg.coll} : 5'h00;
		rx_data_next = (new_evt && evt_reg.byte_ok) ? evt_reg.data : rx_data_reg;
		tx_byte_next = tx_byte_reg;
		tx_req_next = tx_req_reg;
		if (tx_valid && tx_ready) begin
			tx_byte_next = tx_data;
			tx_req_next = !tx_req_reg;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			beat_last_reg <= 1'b0;
			evt_seen_reg <= 1'b0;
			rx_flag_reg <= 5'h00;
			rx_data_reg <= '0;
			tx_byte_reg <= '0;
			tx_req_reg <= 1'b0;
		end else begin
			beat_last_reg <= beat_s;
			evt_seen_reg <= evt_seen_next;
			rx_flag_reg <= rx_flag_next;
			rx_data_reg <= rx_data_next;
			tx_byte_reg <= tx_byte_next;
			tx_req_reg <= tx_req_next;
		end
	end

	assign {rx_valid, rx_parity_err, rx_frame_err, rx_break, rx_collision} = rx_flag_reg;
	assign rx_data = rx_data_reg;
endmodule : dbgp_phy

// ### tb/dbgp_phy_monitor.sv
// Port checker for the debug port physical layer, bound to its top module.
`include "dbgp_cfg.svh"
module dbgp_phy_monitor (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic debug_clock_line,
	input wire logic debug_data_line_o,
	input wire logic debug_data_line_oe_b,
	input wire logic fuse_keep_rst_dis,
	input wire logic tx_ready,
	input wire logic rx_valid,
	input wire logic [`DBGP_DATA_BITS-1:0] rx_data,
	input wire logic rx_parity_err,
	input wire logic rx_frame_err,
	input wire logic rx_collision,
	input wire logic port_active,
	input wire logic rst_fn_en,
	input wire logic core_rst_hold
);
	timeunit 1ns;
	timeprecision 100ps;
	////////////////////////////////////////////////////////////////////////////////
	// The collision pulse trails its link edge, so the driver must already be off.
	sequence s_let_go;
		##4 debug_data_line_oe_b [*8];
	endsequence
	sequence s_quiet;
		##1 !rx_valid [*8];
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	drive_on_change_a: assert property (@(posedge debug_clock_line) disable iff (!rst_b)
		!debug_data_line_oe_b |-> debug_data_line_o != $past(debug_data_line_o))
		else $error("driver on without a bit change");
	coll_release_a: assert property (@(posedge mclk) disable iff (!rst_b)
		rx_collision |-> s_let_go)
		else $error("driver still on after collision");
	good_clean_a: assert property (@(posedge mclk) disable iff (!rst_b)
		rx_valid |-> !rx_parity_err && !rx_frame_err)
		else $error("byte passed with an error flag");
	valid_pulse_a: assert property (@(posedge mclk) disable iff (!rst_b)
		rx_valid |-> s_quiet)
		else $error("byte pulse repeated");
	data_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
		$changed(rx_data) |-> rx_valid || $past(rx_valid))
		else $error("byte changed without a good frame");
	reset_role_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(port_active || fuse_keep_rst_dis) |-> !rst_fn_en)
		else $error("reset role on while port active");
	hold_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
		$fell(port_active) |-> ##[0:2] !core_rst_hold)
		else $error("core reset hold kept after shutdown");
	tx_refuse_a: assert property (@(posedge mclk) disable iff (!rst_b)
		!port_active |-> !tx_ready)
		else $error("byte accepted while inactive");
endmodule : dbgp_phy_monitor

bind dbgp_phy dbgp_phy_monitor mon (
	.mclk(mclk), .rst_b(rst_b), .debug_clock_line(debug_clock_line),
	.debug_data_line_o(debug_data_line_o), .debug_data_line_oe_b(debug_data_line_oe_b),
	.fuse_keep_rst_dis(fuse_keep_rst_dis), .tx_ready(tx_ready), .rx_valid(rx_valid),
	.rx_data(rx_data), .rx_parity_err(rx_parity_err), .rx_frame_err(rx_frame_err),
	.rx_collision(rx_collision), .port_active(port_active), .rst_fn_en(rst_fn_en),
	.core_rst_hold(core_rst_hold)
);

// ### tb/dbgp_prog_model.sv
// Programmer model: link clock, data drive, bus keeper and wire resolution.
module dbgp_prog_model (
	input wire logic run,
	input wire logic dev_o,
	input wire logic dev_oe_b,
	output logic lclk,
	output logic line
);
	timeunit 1ns;
	timeprecision 100ps;
	// Driving high from time zero is what arms the port.
	logic p_drv = 1'b1;
	logic p_val = 1'b1;
	logic keep = 1'b1;
	// The clock stands still low between sessions.
	initial begin
		lclk = 1'b0;
		#3;
		forever begin
			#24;
			if (run || lclk) lclk = ~lclk;
		end
	end
	// The programmer wins a contention, so a collision shows as its level.
	always_comb begin
		if (p_drv) line = p_val;
		else if (!dev_oe_b) line = dev_o;
		else line = keep;
	end
	always @(line) keep = line;
	task put_bit(input logic b);
		@(negedge lclk);
		p_drv = 1'b1;
		p_val = b;
	endtask : put_bit
	task let_go;
		@(negedge lclk);
		p_drv = 1'b0;
	endtask : let_go
	task get_bit(output logic b);
		@(posedge lclk);
		b = line;
	endtask : get_bit
endmodule : dbgp_prog_model

// ### tb/tb_top.sv
// Self-checking bench for the debug port physical layer.
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk, rst_b, fuse, tx_mode, tx_valid, run, lclk, line;
	logic d_o, d_oe_b, tx_ready, rx_valid, perr, ferr, brk, coll, act, rfn, hold;
	logic [7:0] tx_data, rx_data;
	logic [7:0] guard;
	logic [4:0] seen;
	int nb, nv, fail_count, tests_run;
	// Columns: byte, parity flip, stop bits, expected {valid, parity, frame, abort}.
	logic [14:0] rows [6] = '{{8'ha5, 1'b0, 2'b11, 4'h8}, {8'h00, 1'b0, 2'b11, 4'h8},
		{8'hff, 1'b0, 2'b11, 4'h8}, {8'h3c, 1'b1, 2'b11, 4'h4},
		{8'h81, 1'b0, 2'b01, 4'h2}, {8'h7e, 1'b1, 2'b10, 4'h6}};
	dbgp_prog_model prog (.run(run), .dev_o(d_o), .dev_oe_b(d_oe_b), .lclk(lclk), .line(line));
	dbgp_phy #(.START_CYC(200), .IDLE_CYC(200)) uut (.mclk(mclk), .rst_b(rst_b),
		.debug_clock_line(lclk), .debug_data_line_i(line), .debug_data_line_o(d_o),
		.debug_data_line_oe_b(d_oe_b), .fuse_keep_rst_dis(fuse), .guard_cfg(guard),
		.ctl_tx_mode(tx_mode), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_parity_err(perr), .rx_frame_err(ferr),
		.rx_break(brk), .rx_collision(coll), .port_active(act), .rst_fn_en(rfn),
		.core_rst_hold(hold));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// Pulses last one clock, so they are gathered mid-cycle until the bench clears them.
	always @(negedge mclk) begin
		seen = seen | {rx_valid, perr, ferr, brk, coll};
		if (brk === 1'b1) nb++;
		if (rx_valid === 1'b1) nv++;
	end
	////////////////////////////////////////////////////////////////////////////////
	task give_verdict;
		if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	task ran_out;
		fail_count++;
		$display("wrong value at %0t: wait ran out", $time);
		give_verdict();
	endtask : ran_out
	task tick(inout int n, input int lim);
		@(posedge mclk);
		#1;
		n++;
		if (n > lim) ran_out();
	endtask : tick
	task wait_evt;
		int n;
		n = 0;
		while (seen === 5'h00) tick(n, 150);
		repeat (12) @(posedge mclk);
	endtask : wait_evt
	task wait_start(output int hi);
		logic b;
		hi = 0;
		prog.get_bit(b);
		while (b !== 1'b0) begin
			hi++;
			if (hi > 400) ran_out();
			prog.get_bit(b);
		end
	endtask : wait_start
	task send_frame(input logic [7:0] d, input logic pinv, input logic [1:0] sp);
		logic [11:0] f;
		f = {sp, ^d ^ pinv, d, 1'b0};
		for (int i = 0; i < 12; i++) prog.put_bit(f[i]);
	endtask : send_frame
	task rx_case(input logic [7:0] d, input logic pinv, input logic [1:0] sp,
		input logic [3:0] ex);
		seen = 5'h00;
		send_frame(d, pinv, sp);
		prog.put_bit(1'b1);
		wait_evt();
		chk({4'h0, seen[4:1]}, {4'h0, ex}, "rx flags");
		if (ex[3]) chk(rx_data, d, "rx byte");
	endtask : rx_case
	task put_byte(input logic [7:0] d);
		int n;
		n = 0;
		@(posedge mclk) #1 tx_valid = 1'b1;
		tx_data = d;
		while (tx_ready !== 1'b1) tick(n, 3000);
		@(posedge mclk) #1 tx_valid = 1'b0;
	endtask : put_byte
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int n;
		logic [7:0] d;
		logic [2:0] tl;
		rst_b = 1'b0;
		fuse = 1'b0;
		tx_mode = 1'b0;
		tx_valid = 1'b0;
		tx_data = 8'h00;
		guard = 8'h05;
		run = 1'b0;
		seen = 5'h00;
		repeat (19) @(posedge mclk);
		chk(8'(rfn), 8'h01, "reset role");
		chk(8'(d_oe_b), 8'h01, "driver idle");
		@(posedge mclk) #1 rst_b = 1'b1;
		n = 0;
		while (rfn !== 1'b0) tick(n, 400);
		repeat (260) @(posedge mclk);
		chk(8'(rfn), 8'h01, "role back");
		n = 0;
		while (rfn !== 1'b0) tick(n, 400);
		run = 1'b1;
		n = 0;
		while (act !== 1'b1) tick(n, 800);
		chk(8'(rfn), 8'h00, "role off");
		for (int i = 0; i < 6; i++) begin
			rx_case(rows[i][14:7], rows[i][6], rows[i][5:4], rows[i][3:0]);
		end
		seen = 5'h00;
		nv = 0;
		send_frame(8'h5a, 1'b0, 2'b11);
		send_frame(8'hc3, 1'b0, 2'b11);
		prog.put_bit(1'b1);
		wait_evt();
		chk(8'(nv), 8'h02, "back to back");
		chk(rx_data, 8'hc3, "last byte");
		seen = 5'h00;
		nb = 0;
		repeat (14) prog.put_bit(1'b0);
		prog.put_bit(1'b1);
		wait_evt();
		chk({3'h0, seen}, 8'h02, "abort in rx");
		chk(8'(nb), 8'h01, "one abort");
		prog.let_go();
		@(posedge mclk) #1 tx_mode = 1'b1;
		seen = 5'h00;
		nb = 0;
		fork
			begin
				put_byte(8'h96);
				put_byte(8'h00);
				@(posedge mclk) #1 tx_mode = 1'b0;
			end
			begin
				wait_start(n);
				chk(8'(n >= 5 && n <= 13), 8'h01, "guard bits");
				for (int i = 0; i < 8; i++) prog.get_bit(d[i]);
				for (int i = 0; i < 3; i++) prog.get_bit(tl[i]);
				chk(d, 8'h96, "tx byte");
				chk({5'h00, tl}, 8'h06, "tx tail");
				wait_start(n);
				repeat (11) prog.put_bit(1'b0);
				prog.put_bit(1'b1);
				repeat (12) prog.put_bit(1'b0);
				prog.put_bit(1'b1);
			end
		join
		n = 0;
		while (nb == 0) tick(n, 150);
		repeat (12) @(posedge mclk);
		chk({3'h0, seen}, 8'h03, "collision then abort");
		rx_case(8'h3c, 1'b0, 2'b11, 4'h8);
		// A zero setting must give the long default guard before the first start bit.
		@(posedge mclk) #1 guard = 8'h00;
		prog.let_go();
		@(posedge mclk) #1 tx_mode = 1'b1;
		put_byte(8'h4b);
		wait_start(n);
		chk(8'(n >= 128 && n <= 136), 8'h01, "default guard");
		for (int i = 0; i < 8; i++) prog.get_bit(d[i]);
		for (int i = 0; i < 3; i++) prog.get_bit(tl[i]);
		@(posedge mclk) #1 tx_mode = 1'b0;
		chk(d, 8'h4b, "tx byte");
		chk({5'h00, tl}, 8'h06, "tx tail");
		run = 1'b0;
		n = 0;
		while (act !== 1'b0) tick(n, 300);
		chk(8'(rfn), 8'h01, "role restored");
		chk(8'(hold), 8'h00, "hold cleared");
		@(posedge mclk) #1 fuse = 1'b1;
		#1 chk(8'(rfn), 8'h00, "fuse keeps role off");
		give_verdict();
	end
endmodule : tb_top
